// *** rtl/fim_mask_words.sv ***
// interrupt mask words two and three with vector reporting
`timescale 1ns/100ps
module fim_mask_words
    import fim_pkg::*;
#(
    parameter int FILL_W   = 7,
    parameter int JA_DEPTH = 128
) (
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              cs_n,
    input  wire logic              rd_n,
    input  wire logic              wr_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] data_in,
    output logic      [DATA_W-1:0] data_out,
    output logic                   data_oe,
    input  wire logic              irq_ack_n,
    output logic                   irq_n,
    output logic      [7:0]        irq_vector,
    input  wire logic              far_block_err_ovf,
    input  wire logic              check_err_ovf,
    input  wire logic              frame_word_err_ovf,
    input  wire logic              pattern_err_ovf,
    input  wire logic              check_mf_ovf,
    input  wire logic              check_multiframe_aligned_flag,
    input  wire logic              aux_pattern_flag,
    input  wire logic              signalling_mf_sync,
    input  wire logic              check_mf_sync,
    input  wire logic              remote_mf_alarm,
    input  wire logic              one_second_flag,
    input  wire logic              first_timer_flag,
    input  wire logic              second_timer_flag,
    input  wire logic [FILL_W-1:0] jitter_fill
);

    initial begin
        if (JA_DEPTH <= 2 * JA_MARGIN || JA_DEPTH > (1 << FILL_W)) begin
            $error("jitter depth does not fit margin or fill width");
        end
    end

    localparam logic [FILL_W-1:0] FILL_LOW  = FILL_W'(JA_MARGIN);
    localparam logic [FILL_W-1:0] FILL_HIGH = FILL_W'(JA_DEPTH - JA_MARGIN);

    // vector code of a set of pending sources
    function automatic logic [7:0] vec_of(input logic [NUM_SRC-1:0] src);
        logic [7:0] v;
        v = VEC_NONE;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (src[i]) begin
                v = v | SRC_VEC[i];
            end
        end
        return v;
    endfunction

    // microprocessor port pins
    logic [PIN_W-1:0] pin_s;
    logic             wr_n_d;
    logic [7:0]       mask_two;
    logic [7:0]       mask_thr;
    logic [NUM_SRC-1:0] pend;

    fim_sync #(
        .W       (PIN_W),
        .RST_VAL (PIN_RST)
    ) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pin_in   ({cs_n, rd_n, wr_n, irq_ack_n, addr, data_in}),
        .pin_sync (pin_s)
    );

    wire              cs_s   = ~pin_s[PIN_W-1];
    wire              rd_s   = ~pin_s[PIN_W-2];
    wire              wr_n_s = pin_s[PIN_W-3];
    wire              ack_s  = ~pin_s[PIN_W-4];
    wire [ADDR_W-1:0] addr_s = pin_s[DATA_W +: ADDR_W];
    wire [DATA_W-1:0] data_s = pin_s[DATA_W-1:0];

    // write takes effect at the trailing edge of the write strobe
    wire wr_done  = cs_s & wr_n_s & ~wr_n_d;
    wire hit_two  = addr_s == ADDR_MASK_TWO;
    wire hit_thr  = addr_s == ADDR_MASK_THR;
    wire [7:0] rd_mux = hit_two ? mask_two : (hit_thr ? mask_thr : READ_UNMAPPED);

    wire [7:0] next_mask_two = (wr_done && hit_two) ? data_s : mask_two;
    wire [7:0] next_mask_thr = (wr_done && hit_thr) ? (data_s & MASK_THR_USED) : mask_thr;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_n_d   <= 1'b1;
            mask_two <= MASK_RESET;
            mask_thr <= MASK_RESET;
            data_out <= READ_UNMAPPED;
            data_oe  <= 1'b0;
        end else begin
            wr_n_d   <= wr_n_s;
            mask_two <= next_mask_two;
            mask_thr <= next_mask_thr;
            data_out <= rd_mux;
            data_oe  <= cs_s & rd_s;
        end
    end

    // jitter buffer near a limit
    wire jitter_near = (jitter_fill <= FILL_LOW) || (jitter_fill >= FILL_HIGH);

    wire [NUM_LVL-1:0] lvl_pulse;

    fim_edge #(
        .W    (NUM_LVL),
        .RISE (LVL_RISE),
        .FALL (LVL_FALL)
    ) u_edge (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .level    ({jitter_near, second_timer_flag, first_timer_flag, one_second_flag,
                    remote_mf_alarm, check_mf_sync, signalling_mf_sync,
                    aux_pattern_flag, check_multiframe_aligned_flag}),
        .pulse    (lvl_pulse)
    );

    // source events in mask bit order
    logic [NUM_SRC-1:0] evt;
    always_comb begin
        evt                               = '0;
        evt[BIT_CHECK_MF_OVF]             = check_mf_ovf;
        evt[BIT_AUX_PATTERN]              = lvl_pulse[1];
        evt[BIT_PATTERN_OVF]              = pattern_err_ovf;
        evt[BIT_JITTER_LIMIT]             = lvl_pulse[8];
        evt[BIT_FRAME_WORD_OVF]           = frame_word_err_ovf;
        evt[BIT_ALIGN_CHANGE]             = lvl_pulse[0];
        evt[BIT_CHECK_ERR_OVF]            = check_err_ovf;
        evt[BIT_FAR_BLOCK_OVF]            = far_block_err_ovf;
        evt[THR_BASE + BIT_SECOND_TIMER]  = lvl_pulse[7];
        evt[THR_BASE + BIT_FIRST_TIMER]   = lvl_pulse[6];
        evt[THR_BASE + BIT_ONE_SECOND]    = lvl_pulse[5];
        evt[THR_BASE + BIT_REMOTE_ALARM]  = lvl_pulse[4];
        evt[THR_BASE + BIT_CHECK_MF_LOSS] = lvl_pulse[3];
        evt[THR_BASE + BIT_SIG_MF_LOSS]   = lvl_pulse[2];
    end

    // only enabled events latch; a new event beats the acknowledge
    wire [NUM_SRC-1:0] enable    = {mask_thr & MASK_THR_USED, mask_two};
    wire [NUM_SRC-1:0] set       = evt & enable;
    wire [NUM_SRC-1:0] next_pend = (ack_s ? '0 : pend) | set;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend       <= '0;
            irq_n      <= 1'b1;
            irq_vector <= VEC_NONE;
        end else begin
            pend       <= next_pend;
            irq_n      <= ~|next_pend;
            irq_vector <= vec_of(next_pend);
        end
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    AST_FAR_BLOCK: assert property (
        far_block_err_ovf && mask_two[BIT_FAR_BLOCK_OVF]
        |=> !irq_n && (irq_vector & VEC_COUNTER) == VEC_COUNTER)
        else $error("far block overflow did not interrupt");
    AST_CHECK_ERR: assert property (
        check_err_ovf && mask_two[BIT_CHECK_ERR_OVF]
        |=> !irq_n && irq_vector[4])
        else $error("check error overflow did not interrupt");
    AST_ALIGN_CHANGE: assert property (
        ($rose(check_multiframe_aligned_flag) || $fell(check_multiframe_aligned_flag))
        && $past(rst_n) && mask_two[BIT_ALIGN_CHANGE]
        |=> !irq_n && irq_vector[3])
        else $error("alignment change did not interrupt");
    AST_FRAME_WORD: assert property (
        frame_word_err_ovf && mask_two[BIT_FRAME_WORD_OVF] |=> irq_vector[4] && !irq_n)
        else $error("frame word overflow did not interrupt");
    AST_JITTER: assert property (
        $rose(jitter_near) && $past(rst_n) && mask_two[BIT_JITTER_LIMIT]
        |=> !irq_n && (irq_vector & VEC_JITTER) == VEC_JITTER)
        else $error("jitter limit did not interrupt");
    AST_PATTERN: assert property (
        pattern_err_ovf && mask_two[BIT_PATTERN_OVF] |=> !irq_n && irq_vector[4])
        else $error("pattern overflow did not interrupt");
    AST_AUX: assert property (
        $rose(aux_pattern_flag) && $past(rst_n) && mask_two[BIT_AUX_PATTERN]
        |=> !irq_n && irq_vector[6])
        else $error("aux pattern rise did not interrupt");
    AST_CHECK_MF_OVF: assert property (
        check_mf_ovf && mask_two[BIT_CHECK_MF_OVF] |=> !irq_n && irq_vector[4])
        else $error("multiframe counter overflow did not interrupt");
    AST_ALL_MASKED: assert property (
        irq_n && !ack_s && !wr_done && mask_two == MASK_RESET && mask_thr == MASK_RESET
        |=> irq_n[*2])
        else $error("interrupt with every source masked");
    AST_SIG_LOSS: assert property (
        $fell(signalling_mf_sync) && $past(rst_n) && mask_thr[BIT_SIG_MF_LOSS]
        |=> !irq_n && irq_vector[7])
        else $error("signalling sync loss did not interrupt");
    AST_CHECK_LOSS: assert property (
        $fell(check_mf_sync) && $past(rst_n) && mask_thr[BIT_CHECK_MF_LOSS]
        |=> !irq_n && irq_vector[7])
        else $error("check sync loss did not interrupt");
    AST_REMOTE: assert property (
        $rose(remote_mf_alarm) && $past(rst_n) && mask_thr[BIT_REMOTE_ALARM]
        |=> !irq_n && irq_vector[7])
        else $error("remote alarm did not interrupt");
    AST_ONE_SEC: assert property (
        $rose(one_second_flag) && $past(rst_n) && mask_thr[BIT_ONE_SECOND]
        |=> !irq_n && irq_vector[3])
        else $error("one second rise did not interrupt");
    AST_TIMER_ONE: assert property (
        $rose(first_timer_flag) && $past(rst_n) && mask_thr[BIT_FIRST_TIMER]
        |=> !irq_n && irq_vector[3])
        else $error("first timer rise did not interrupt");
    AST_TIMER_TWO: assert property (
        $rose(second_timer_flag) && $past(rst_n) && mask_thr[BIT_SECOND_TIMER]
        |=> !irq_n && irq_vector[3])
        else $error("second timer rise did not interrupt");
    AST_UNUSED_BITS: assert property (
        cs_s && rd_s && hit_thr |=> (data_out & ~MASK_THR_USED) == 8'h00)
        else $error("unused mask bits read nonzero");
    AST_MASKED_QUIET: assert property (
        set == '0 && !ack_s |=> $stable(irq_vector) && $stable(irq_n))
        else $error("masked event changed interrupt state");

    // acknowledge and pending sources
    AST_ACK_CLEARS: assert property (
        ack_s && set == '0 |=> irq_n && irq_vector == VEC_NONE)
        else $error("acknowledge did not clear the interrupt");
    AST_SET_BEATS_ACK: assert property (
        ack_s && set != '0 |=> !irq_n && pend == $past(set))
        else $error("event lost during acknowledge");
    AST_PEND_HOLDS: assert property (
        !ack_s |=> (pend & $past(pend)) == $past(pend))
        else $error("pending source dropped without acknowledge");
    AST_NO_EVENT_QUIET: assert property (
        irq_n && set == '0 |=> irq_n)
        else $error("interrupt without an enabled event");
    AST_IRQ_AGREES: assert property (
        irq_n == (irq_vector == VEC_NONE))
        else $error("interrupt level and vector disagree");
    AST_UNUSED_QUIET: assert property (
        (pend[NUM_SRC-1:THR_BASE] & ~MASK_THR_USED) == 8'h00)
        else $error("unused mask position became pending");
    AST_THR_STORED: assert property (
        (mask_thr & ~MASK_THR_USED) == 8'h00)
        else $error("unused mask bit stored");

    // register port
    AST_WRITE_TWO: assert property (
        wr_done && hit_two |=> mask_two == $past(data_s))
        else $error("mask word two write lost");
    AST_WRITE_THR: assert property (
        wr_done && hit_thr |=> mask_thr == ($past(data_s) & MASK_THR_USED))
        else $error("mask word three write lost");
    AST_MASK_HOLD: assert property (
        !wr_done |=> $stable(mask_two) && $stable(mask_thr))
        else $error("mask changed without a write");
    AST_READ_TWO: assert property (
        cs_s && rd_s && hit_two |=> data_oe && data_out == $past(mask_two))
        else $error("mask word two read wrong");
    AST_READ_THR: assert property (
        cs_s && rd_s && hit_thr |=> data_oe && data_out == $past(mask_thr))
        else $error("mask word three read wrong");
    AST_READ_OTHER: assert property (
        cs_s && rd_s && !hit_two && !hit_thr |=> data_out == READ_UNMAPPED)
        else $error("unmapped read not zero");
    AST_OE_READ: assert property (
        cs_s && rd_s |=> data_oe)
        else $error("read data not driven during a read");
    AST_OE_IDLE: assert property (
        !(cs_s && rd_s) |=> !data_oe)
        else $error("read data driven outside a read");

    COV_COUNTER_IRQ: cover property (far_block_err_ovf && mask_two[BIT_FAR_BLOCK_OVF] ##1 !irq_n);
    COV_ACK_CLEAR:   cover property (!irq_n && ack_s ##1 irq_n);
    COV_MASK_WRITE:  cover property (wr_done && hit_thr);
    COV_SET_ON_ACK:  cover property (ack_s && set != '0);
    COV_ALIGN_FALL:  cover property (
        $fell(check_multiframe_aligned_flag) && mask_two[BIT_ALIGN_CHANGE] ##1 !irq_n);

endmodule

// *** rtl/fim_pkg.sv ***
// constants shared by the interrupt mask word block
package fim_pkg;

    // register map on the microprocessor port
    localparam int         ADDR_W        = 5;
    localparam int         DATA_W        = 8;
    localparam logic [4:0] ADDR_MASK_TWO = 5'h1D;
    localparam logic [4:0] ADDR_MASK_THR = 5'h1E;
    localparam logic [7:0] MASK_RESET    = 8'h00;
    localparam logic [7:0] MASK_THR_USED = 8'hDE;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // mask word two bit positions
    localparam int BIT_CHECK_MF_OVF   = 0;
    localparam int BIT_AUX_PATTERN    = 1;
    localparam int BIT_PATTERN_OVF    = 2;
    localparam int BIT_JITTER_LIMIT   = 3;
    localparam int BIT_FRAME_WORD_OVF = 4;
    localparam int BIT_ALIGN_CHANGE   = 5;
    localparam int BIT_CHECK_ERR_OVF  = 6;
    localparam int BIT_FAR_BLOCK_OVF  = 7;

    // mask word three bit positions
    localparam int BIT_SECOND_TIMER   = 1;
    localparam int BIT_FIRST_TIMER    = 2;
    localparam int BIT_ONE_SECOND     = 3;
    localparam int BIT_REMOTE_ALARM   = 4;
    localparam int BIT_CHECK_MF_LOSS  = 6;
    localparam int BIT_SIG_MF_LOSS    = 7;

    // source index in the combined sixteen bit word {word three, word two}
    localparam int NUM_SRC   = 16;
    localparam int THR_BASE  = 8;

    // interrupt vector codes
    localparam logic [7:0] VEC_NONE      = 8'h00;
    localparam logic [7:0] VEC_SYNC_LOSS = 8'h80;
    localparam logic [7:0] VEC_AUX       = 8'h40;
    localparam logic [7:0] VEC_COUNTER   = 8'h10;
    localparam logic [7:0] VEC_STATUS    = 8'h08;
    localparam logic [7:0] VEC_JITTER    = 8'h04;

    // vector for each source, index 15 first
    localparam logic [NUM_SRC-1:0][7:0] SRC_VEC = {
        VEC_SYNC_LOSS, VEC_SYNC_LOSS, VEC_NONE,   VEC_SYNC_LOSS,
        VEC_STATUS,    VEC_STATUS,    VEC_STATUS, VEC_NONE,
        VEC_COUNTER,   VEC_COUNTER,   VEC_STATUS, VEC_COUNTER,
        VEC_JITTER,    VEC_COUNTER,   VEC_AUX,    VEC_COUNTER
    };

    // jitter buffer margin in bytes
    localparam int JA_MARGIN = 4;

    // level sources through the edge detector
    localparam int NUM_LVL = 9;
    // bit order: align, aux, sig sync, check sync, remote alarm, 1 s, t1, t2, jitter
    localparam logic [NUM_LVL-1:0] LVL_RISE = 9'h1F3;
    localparam logic [NUM_LVL-1:0] LVL_FALL = 9'h00D;

    // pin synchroniser reset image: {cs_n, rd_n, wr_n, ack_n, addr, data}
    localparam int          PIN_W   = 4 + ADDR_W + DATA_W;
    localparam logic [16:0] PIN_RST = 17'h1E000;

endpackage

// *** rtl/fim_sync.sv ***
// two flip-flop synchroniser for pins
`timescale 1ns/100ps
module fim_sync
    import fim_pkg::*;
#(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_sync
);

    logic [W-1:0] meta;

    initial begin
        if (W < 1) begin
            $error("fim_sync width must be at least one");
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta     <= RST_VAL;
            pin_sync <= RST_VAL;
        end else begin
            meta     <= pin_in;
            pin_sync <= meta;
        end
    end

endmodule

// *** rtl/fim_edge.sv ***
// edge detector for status levels, primed on the first cycle after reset
`timescale 1ns/100ps
module fim_edge
    import fim_pkg::*;
#(
    parameter int           W    = 1,
    parameter logic [W-1:0] RISE = '1,
    parameter logic [W-1:0] FALL = '0
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] level,
    output logic      [W-1:0] pulse
);

    logic [W-1:0] prev;
    logic         primed;

    wire  [W-1:0] rose = level & ~prev;
    wire  [W-1:0] fell = ~level & prev;

    // no pulse until the previous level is known
    assign pulse = primed ? ((rose & RISE) | (fell & FALL)) : '0;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev   <= '0;
            primed <= 1'b0;
        end else begin
            prev   <= level;
            primed <= 1'b1;
        end
    end

endmodule

// *** verification/test_framer_interrupt_mask_words.sv ***
// self-checking bench for the interrupt mask word block
`timescale 1ns/100ps
module test_framer_interrupt_mask_words;
    import fim_pkg::*;

    logic              core_clk;
    logic              rst_n;
    logic              cs_n;
    logic              rd_n;
    logic              wr_n;
    logic [4:0]        addr;
    logic [7:0]        data_in;
    logic [7:0]        data_out;
    logic              data_oe;
    logic              irq_ack_n;
    logic              irq_n;
    logic [7:0]        irq_vector;
    logic              far_ovf, chk_ovf, fw_ovf, pat_ovf, cmf_ovf;
    logic              align_flag, aux_flag, sig_sync, chk_sync, rem_alarm;
    logic              sec_flag, t1_flag, t2_flag;
    logic [6:0]        jitter_fill;
    int                fail_count;
    int                n_compared;

    // expected vector per source index {word three, word two}
    localparam logic [7:0] EXP_VEC [16] = '{8'h10, 8'h40, 8'h10, 8'h04, 8'h10, 8'h08, 8'h10,
        8'h10, 8'h00, 8'h08, 8'h08, 8'h08, 8'h80, 8'h00, 8'h80, 8'h80};
    localparam int SRCS [16] = '{0, 1, 2, 3, 3, 4, 5, 5, 6, 7, 9, 10, 11, 12, 14, 15};

    fim_mask_words #(.FILL_W(7), .JA_DEPTH(128)) i_dut (
        .core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .irq_ack_n(irq_ack_n), .irq_n(irq_n), .irq_vector(irq_vector),
        .far_block_err_ovf(far_ovf), .check_err_ovf(chk_ovf), .frame_word_err_ovf(fw_ovf),
        .pattern_err_ovf(pat_ovf), .check_mf_ovf(cmf_ovf),
        .check_multiframe_aligned_flag(align_flag), .aux_pattern_flag(aux_flag),
        .signalling_mf_sync(sig_sync), .check_mf_sync(chk_sync),
        .remote_mf_alarm(rem_alarm), .one_second_flag(sec_flag),
        .first_timer_flag(t1_flag), .second_timer_flag(t2_flag), .jitter_fill(jitter_fill));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        cs_n = 1'b0;
        addr = a;
        data_in = d;
        wr_n = 1'b0;
        step(4);
        wr_n = 1'b1;
        step(4);
        cs_n = 1'b1;
        step(4);
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        cs_n = 1'b0;
        rd_n = 1'b0;
        addr = a;
        step(5);
        check({7'h00, data_oe}, 8'h01);
        check(data_out, e);
        rd_n = 1'b1;
        cs_n = 1'b1;
        step(5);
        check({7'h00, data_oe}, 8'h00);
    endtask

    task automatic setm(input logic [15:0] v);
        wr(5'h1D, v[7:0]);
        wr(5'h1E, v[15:8]);
    endtask

    // drive the event of one source, pulses last one cycle
    task automatic trig(input int i, input bit alt);
        case (i)
            0: cmf_ovf = 1'b1;
            1: aux_flag = 1'b1;
            2: pat_ovf = 1'b1;
            3: jitter_fill = alt ? 7'h7C : 7'h04;
            4: fw_ovf = 1'b1;
            5: align_flag = ~align_flag;
            6: chk_ovf = 1'b1;
            7: far_ovf = 1'b1;
            9: t2_flag = 1'b1;
            10: t1_flag = 1'b1;
            11: sec_flag = 1'b1;
            12: rem_alarm = 1'b1;
            14: chk_sync = 1'b0;
            15: sig_sync = 1'b0;
            default: ;
        endcase
        step(1);
        {far_ovf, chk_ovf, fw_ovf, pat_ovf, cmf_ovf} = 5'h00;
        step(3);
    endtask

    // return levels to rest; none of these moves is an event
    task automatic idle;
        {aux_flag, t1_flag, t2_flag, sec_flag, rem_alarm} = 5'h00;
        {sig_sync, chk_sync} = 2'b11;
        jitter_fill = 7'h40;
        step(3);
    endtask

    task automatic ack;
        irq_ack_n = 1'b0;
        step(5);
        check({7'h00, irq_n}, 8'h01);
        check(irq_vector, 8'h00);
        irq_ack_n = 1'b1;
        step(4);
    endtask

    task conclude;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #(6000 * 40);
        fail_count++;
        conclude();
    end

    initial begin
        fail_count = 0;
        n_compared = 0;
        rst_n = 1'b0;
        {cs_n, rd_n, wr_n, irq_ack_n} = 4'hF;
        addr = 5'h00;
        data_in = 8'h00;
        {far_ovf, chk_ovf, fw_ovf, pat_ovf, cmf_ovf, align_flag} = 6'h00;
        {aux_flag, t1_flag, t2_flag, sec_flag, rem_alarm} = 5'h00;
        {sig_sync, chk_sync} = 2'b11;
        jitter_fill = 7'h40;
        step(4);
        rst_n = 1'b1;
        step(1);
        check({7'h00, irq_n}, 8'h01);
        check(irq_vector, 8'h00);
        step(2);
        rd(5'h1D, 8'h00);
        rd(5'h1E, 8'h00);
        wr(5'h1E, 8'hFF);
        rd(5'h1E, 8'hDE);
        wr(5'h1D, 8'hFF);
        rd(5'h1D, 8'hFF);
        rd(5'h1C, 8'h00);
        // two sources pending at once give the union of their vectors
        trig(6, 1'b0);
        trig(11, 1'b0);
        check(irq_vector, 8'h18);
        ack();
        setm(16'h0000);
        idle();
        // every event with all sources masked
        for (int k = 0; k < 16; k++) begin
            trig(SRCS[k], k == 4);
            check({7'h00, irq_n}, 8'h01);
            idle();
        end
        // each source alone, both jitter limits, both alignment edges
        for (int k = 0; k < 16; k++) begin
            setm(16'h0001 << SRCS[k]);
            trig(SRCS[k], k == 4);
            check({7'h00, irq_n}, 8'h00);
            check(irq_vector, EXP_VEC[SRCS[k]]);
            ack();
            idle();
            check({7'h00, irq_n}, 8'h01);
        end
        // jitter fill one byte short of either limit
        setm(16'h0008);
        jitter_fill = 7'h05;
        step(3);
        jitter_fill = 7'h7B;
        step(3);
        check({7'h00, irq_n}, 8'h01);
        idle();
        // an event in an acknowledge cycle still interrupts
        setm(16'h0040);
        irq_ack_n = 1'b0;
        step(3);
        chk_ovf = 1'b1;
        step(1);
        chk_ovf = 1'b0;
        check({7'h00, irq_n}, 8'h00);
        check(irq_vector, 8'h10);
        irq_ack_n = 1'b1;
        step(4);
        check({7'h00, irq_n}, 8'h01);
        // a pending source survives clearing its mask
        setm(16'h0080);
        trig(7, 1'b0);
        wr(5'h1D, 8'h00);
        check(irq_vector, 8'h10);
        ack();
        conclude();
    end
endmodule
